/* File: pin_remap_pkg.sv */
package pin_remap_pkg;

    // ==========================================================
    // Register map, byte addresses on the bus.
    localparam logic [7:0] OFS_INPUT_REMAP = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_REMAP = 8'h04;
    localparam logic [7:0] OFS_WAKE_ENABLE = 8'h08;
    localparam logic [7:0] OFS_BIT_OP = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_DATA_BASE = 8'h20;
    localparam logic [7:0] OFS_DIR_BASE = 8'h40;
    localparam logic [7:0] OFS_LEVEL_BASE = 8'h60;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] RST_REMAP = 8'h00;
    localparam logic [7:0] RST_PORT = 8'hFF;
    localparam logic [7:0] RST_WAKE = 8'h00;

    // ==========================================================
    // Field positions of the input remap register.
    localparam int TIMER2_CLOCK_IN_SEL = 7;
    localparam int TIMER1_CLOCK_IN_SEL = 6;
    localparam int TIMER0_CLOCK_IN_SEL = 5;
    localparam int IRQ2_IN_SEL = 4;
    localparam int IRQ1_IN_SEL_HI = 3;
    localparam int IRQ1_IN_SEL_LO = 2;
    localparam int IRQ0_IN_SEL_HI = 1;
    localparam int IRQ0_IN_SEL_LO = 0;

    // ==========================================================
    // Output remap bits; bit i steers timer output i.
    localparam int TIMER0_OUT_A_SEL = 0;
    localparam int TIMER0_OUT_B_SEL = 1;
    localparam int TIMER1_CHANA_SEL = 2;
    localparam int TIMER1_CHANB_THIRD_SEL = 3;
    localparam int TIMER2_OUT_A_SEL = 4;
    localparam int TIMER2_OUT_B_SEL = 5;
    localparam int TIMER3_OUT_A_SEL = 6;
    localparam int TIMER3_OUT_B_SEL = 7;
    localparam logic [7:0] SMALL_REMAP_MASK = 8'h3F;

    // ==========================================================
    // Bit operation and status register fields.
    localparam int BITOP_BIT_LSB = 0;
    localparam int BITOP_PORT_LSB = 4;
    localparam int BITOP_DIR = 8;
    localparam int BITOP_SET = 9;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_SLEEP = 1;

    // ==========================================================
    // Pin index is port times eight plus line; port A is zero.
    localparam logic [5:0] PIN_A0 = 6'h00;
    localparam logic [5:0] PIN_A1 = 6'h01;
    localparam logic [5:0] PIN_A2 = 6'h02;
    localparam logic [5:0] PIN_A3 = 6'h03;
    localparam logic [5:0] PIN_A4 = 6'h04;
    localparam logic [5:0] PIN_C2 = 6'h12;
    localparam logic [5:0] PIN_C3 = 6'h13;
    localparam logic [5:0] PIN_C4 = 6'h14;
    localparam logic [5:0] PIN_C5 = 6'h15;
    localparam logic [5:0] PIN_C6 = 6'h16;
    localparam logic [5:0] PIN_C7 = 6'h17;
    localparam logic [5:0] PIN_D0 = 6'h18;
    localparam logic [5:0] PIN_D1 = 6'h19;
    localparam logic [5:0] PIN_D2 = 6'h1A;
    localparam logic [5:0] PIN_D3 = 6'h1B;
    localparam logic [5:0] PIN_D4 = 6'h1C;
    localparam logic [5:0] PIN_D5 = 6'h1D;
    localparam logic [5:0] PIN_E0 = 6'h20;
    localparam logic [5:0] PIN_E1 = 6'h21;
    localparam logic [5:0] PIN_E3 = 6'h23;
    localparam logic [5:0] PIN_E4 = 6'h24;
    localparam logic [5:0] PIN_E5 = 6'h25;
    localparam logic [5:0] PIN_E6 = 6'h26;
    localparam logic [5:0] PIN_E7 = 6'h27;

    localparam logic [5:0] TOUT_PIN_CLR [8] = '{PIN_A0, PIN_C5, PIN_A1, PIN_C5,
                                                PIN_C3, PIN_C4, PIN_D3, PIN_D0};
    localparam logic [5:0] TOUT_PIN_SET [8] = '{PIN_C6, PIN_D5, PIN_C7, PIN_E4,
                                                PIN_D1, PIN_D4, PIN_E5, PIN_E3};
    localparam logic [5:0] IRQ0_PIN [4] = '{PIN_A3, PIN_C4, PIN_E0, PIN_E6};
    localparam logic [5:0] IRQ1_PIN [4] = '{PIN_A4, PIN_C5, PIN_E1, PIN_E7};

endpackage

/* File: peripheral_pin_remap.sv */
// Summary of operation
// - Timer2 clock from C2, or D0 when set.
// - Timer1 clock from A4, or D3 when set.
// - Timer0 clock from A2, or D2 when set.
// - Irq1 select: A4, C5, E1, E7.
// - Irq0 select: A3, C4, E0, E6.
// - Small variant output bits 7:6 read zero.
// - Timer2 output B on C4, or D4.
// - Timer2 output A on C3, or D1.
// - Timer1 channel B third on C5, or E4.
// - Timer1 channel A on A1, or C7.
// - Timer0 output B on C5, or D5.
// - Timer0 output A on A0, or C6.
// - Large variant timer3 output B D0/E3.
// - Large variant timer3 output A D3/E5.
// - Reset sets all port data, direction ones.
// - Output pin drives its port data bit.
// - Bit operations read, modify, write whole port.
// - Sleeping, enabled port A falling edge wakes.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
module peripheral_pin_remap
    import pin_remap_pkg::*;
#(
    parameter int NPORT = 7,
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock, reset and clock enable.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Avalon-MM slave.
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Port pins.
    input wire logic [NPORT*8-1:0] PIN_IN,
    output logic [NPORT*8-1:0] PIN_OUT,
    output logic [NPORT*8-1:0] PIN_OE_N,
    // Timer side.
    input wire logic [7:0] TOUT,
    input wire logic [7:0] TOUT_EN,
    output logic [2:0] TMR_CLK_IN,
    output logic [1:0] IRQ_IN,
    // Power control.
    input wire logic SLEEP,
    output logic WAKE
);

    localparam int NPIN = NPORT * 8;

    typedef enum logic [1:0] {
        S_IDLE,
        S_RMW_READ,
        S_RMW_WRITE
    } bitop_state_t;

    typedef struct packed {
        bitop_state_t fsm;
        logic waitreq;
        logic [31:0] readdata;
        logic [7:0] in_remap;
        logic [7:0] out_remap;
        logic [7:0] wake_en;
        logic [NPORT-1:0][7:0] port_data;
        logic [NPORT-1:0][7:0] port_dir;
        logic [NPIN-1:0] pin_s1;
        logic [NPIN-1:0] pin_s2;
        logic [7:0] port_a_prev;
        logic [2:0] op_port;
        logic [2:0] op_bit;
        logic op_dir;
        logic op_set;
        logic [7:0] op_byte;
        logic [NPIN-1:0] pin_out;
        logic [NPIN-1:0] pin_oe_n;
        logic [2:0] tclk;
        logic [1:0] irq;
        logic wake;
    } state_t;

    state_t st;
    state_t next_st;

    logic req;
    logic [7:0] wbyte;
    logic [7:0] out_mask;
    logic [2:0] aport;

    assign req = READ | WRITE;
    assign wbyte = WRITEDATA[7:0];
    assign out_mask = LARGE_VARIANT ? 8'hFF : SMALL_REMAP_MASK;
    assign aport = ADDRESS[4:2];

    // ==========================================================
    // Read multiplexer.
    function automatic logic [7:0] read_value(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        logic [2:0] p;
        v = 8'h00;
        p = a[4:2];
        if (a == OFS_INPUT_REMAP) begin
            v = s.in_remap;
        end else if (a == OFS_OUTPUT_REMAP) begin
            v = s.out_remap & out_mask;
        end else if (a == OFS_WAKE_ENABLE) begin
            v = s.wake_en;
        end else if (a == OFS_STATUS) begin
            v[STATUS_BUSY] = (s.fsm != S_IDLE);
            v[STATUS_SLEEP] = SLEEP;
        end else if (int'(p) < NPORT) begin
            if ((a & 8'hE3) == OFS_DATA_BASE) begin
                v = s.port_data[p];
            end else if ((a & 8'hE3) == OFS_DIR_BASE) begin
                v = s.port_dir[p];
            end else if ((a & 8'hE3) == OFS_LEVEL_BASE) begin
                v = s.pin_s2[p*8 +: 8];
            end
        end
        return v;
    endfunction

    // ==========================================================
    // Next state.
    always_comb begin
        next_st = st;
        next_st.wake = 1'b0;

        // Pin synchronisers.
        next_st.pin_s1 = PIN_IN;
        next_st.pin_s2 = st.pin_s1;

        // Bus handshake: held while a bit operation runs, then one wait cycle, then the access completes.
        if (req && st.waitreq && st.fsm == S_IDLE) begin
            next_st.waitreq = 1'b0;
            next_st.readdata = {24'h000000, read_value(st, ADDRESS)};
        end else begin
            next_st.waitreq = 1'b1;
        end

        if (WRITE && !st.waitreq && BYTEENABLE[0]) begin
            if (ADDRESS == OFS_INPUT_REMAP) begin
                next_st.in_remap = wbyte;
            end else if (ADDRESS == OFS_OUTPUT_REMAP) begin
                next_st.out_remap = wbyte & out_mask;
            end else if (ADDRESS == OFS_WAKE_ENABLE) begin
                next_st.wake_en = wbyte;
            end else if (ADDRESS == OFS_BIT_OP) begin
                if (int'(WRITEDATA[BITOP_PORT_LSB +: 3]) < NPORT) begin
                    next_st.op_bit = WRITEDATA[BITOP_BIT_LSB +: 3];
                    next_st.op_port = WRITEDATA[BITOP_PORT_LSB +: 3];
                    next_st.op_dir = WRITEDATA[BITOP_DIR];
                    next_st.op_set = WRITEDATA[BITOP_SET];
                    next_st.fsm = S_RMW_READ;
                end
            end else if (int'(aport) < NPORT) begin
                if ((ADDRESS & 8'hE3) == OFS_DATA_BASE) begin
                    next_st.port_data[aport] = wbyte;
                end else if ((ADDRESS & 8'hE3) == OFS_DIR_BASE) begin
                    next_st.port_dir[aport] = wbyte;
                end
            end
        end

        // Bit operation: whole byte read, one bit changed, byte written back.
        case (st.fsm)
            S_IDLE: begin
            end
            S_RMW_READ: begin
                next_st.op_byte = st.op_dir ? st.port_dir[st.op_port]
                                            : st.port_data[st.op_port];
                next_st.fsm = S_RMW_WRITE;
            end
            S_RMW_WRITE: begin
                next_st.op_byte[st.op_bit] = st.op_set;
                if (st.op_dir) begin
                    next_st.port_dir[st.op_port] = next_st.op_byte;
                end else begin
                    next_st.port_data[st.op_port] = next_st.op_byte;
                end
                next_st.fsm = S_IDLE;
            end
            default: begin
                next_st.fsm = S_IDLE;
            end
        endcase

        // Pin drive: port latch first, then any selected timer output.
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                next_st.pin_out[p*8+b] = st.port_data[p][b];
                next_st.pin_oe_n[p*8+b] = st.port_dir[p][b];
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (TOUT_EN[i] && (i < 6 || LARGE_VARIANT)) begin
                // Only the selected pin is taken; the other reverts.
                if (st.out_remap[i]) begin
                    next_st.pin_out[TOUT_PIN_SET[i]] = TOUT[i];
                    next_st.pin_oe_n[TOUT_PIN_SET[i]] = 1'b0;
                end else begin
                    next_st.pin_out[TOUT_PIN_CLR[i]] = TOUT[i];
                    next_st.pin_oe_n[TOUT_PIN_CLR[i]] = 1'b0;
                end
            end
        end

        // Peripheral inputs from the selected pins.
        next_st.tclk[2] = st.in_remap[TIMER2_CLOCK_IN_SEL] ? st.pin_s2[PIN_D0]
                                                         : st.pin_s2[PIN_C2];
        next_st.tclk[1] = st.in_remap[TIMER1_CLOCK_IN_SEL] ? st.pin_s2[PIN_D3]
                                                         : st.pin_s2[PIN_A4];
        next_st.tclk[0] = st.in_remap[TIMER0_CLOCK_IN_SEL] ? st.pin_s2[PIN_D2]
                                                         : st.pin_s2[PIN_A2];
        next_st.irq[1] = st.pin_s2[IRQ1_PIN[st.in_remap[IRQ1_IN_SEL_HI:IRQ1_IN_SEL_LO]]];
        next_st.irq[0] = st.pin_s2[IRQ0_PIN[st.in_remap[IRQ0_IN_SEL_HI:IRQ0_IN_SEL_LO]]];

        // Wake on a falling edge of an enabled port A pin.
        next_st.port_a_prev = st.pin_s2[7:0];
        if (SLEEP && |(st.port_a_prev & ~st.pin_s2[7:0] & st.wake_en)) begin
            next_st.wake = 1'b1;
        end
    end

    // ==========================================================
    // State register.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st.fsm <= S_IDLE;
            st.waitreq <= 1'b1;
            st.readdata <= 32'h00000000;
            st.in_remap <= RST_REMAP;
            st.out_remap <= RST_REMAP;
            st.wake_en <= RST_WAKE;
            st.port_data <= {NPORT{RST_PORT}};
            st.port_dir <= {NPORT{RST_PORT}};
            st.pin_s1 <= '0;
            st.pin_s2 <= '0;
            st.port_a_prev <= 8'h00;
            st.op_port <= 3'h0;
            st.op_bit <= 3'h0;
            st.op_dir <= 1'b0;
            st.op_set <= 1'b0;
            st.op_byte <= 8'h00;
            st.pin_out <= '1;
            st.pin_oe_n <= '1;
            st.tclk <= 3'h0;
            st.irq <= 2'h0;
            st.wake <= 1'b0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign READDATA = st.readdata;
    assign WAITREQUEST = st.waitreq;
    assign PIN_OUT = st.pin_out;
    assign PIN_OE_N = st.pin_oe_n;
    assign TMR_CLK_IN = st.tclk;
    assign IRQ_IN = st.irq;
    assign WAKE = st.wake;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_timer2_clock_route: assert property (CE |=> TMR_CLK_IN[2] ==
        $past(st.in_remap[7] ? st.pin_s2[24] : st.pin_s2[18]))
        else $error("Timer2 clock input taken from wrong pin.");

    a_timer1_clock_route: assert property (CE |=> TMR_CLK_IN[1] ==
        $past(st.in_remap[6] ? st.pin_s2[27] : st.pin_s2[4]))
        else $error("Timer1 clock input taken from wrong pin.");

    a_timer0_clock_route: assert property (CE |=> TMR_CLK_IN[0] ==
        $past(st.in_remap[5] ? st.pin_s2[26] : st.pin_s2[2]))
        else $error("Timer0 clock input taken from wrong pin.");

    a_irq1_e1_route: assert property ((CE && st.in_remap[3:2] == 2'h2) |=>
        IRQ_IN[1] == $past(st.pin_s2[33]))
        else $error("Irq1 not taken from E1.");

    a_irq0_e6_route: assert property ((CE && st.in_remap[1:0] == 2'h3) |=>
        IRQ_IN[0] == $past(st.pin_s2[38]))
        else $error("Irq0 not taken from E6.");

    a_small_upper_zero: assert property (!LARGE_VARIANT |-> st.out_remap[7:6] == 2'h0)
        else $error("Unimplemented output remap bits set.");

    a_timer0_a_alt: assert property ((CE && TOUT_EN[0] && st.out_remap[0]) |=>
        PIN_OUT[22] == $past(TOUT[0]) && !PIN_OE_N[22])
        else $error("Timer0 output A not on C6.");

    a_timer2_b_alt: assert property ((CE && TOUT_EN[5] && st.out_remap[5]) |=>
        PIN_OUT[28] == $past(TOUT[5]) && !PIN_OE_N[28])
        else $error("Timer2 output B not on D4.");

    a_timer3_b_dflt: assert property ((CE && LARGE_VARIANT && TOUT_EN[7]
        && !st.out_remap[7]) |=> PIN_OUT[24] == $past(TOUT[7]) && !PIN_OE_N[24])
        else $error("Timer3 output B not on D0.");

    a_reset_ports_high: assert property ($rose(RST_N) |->
        st.port_data == {NPORT{8'hFF}} && st.port_dir == {NPORT{8'hFF}})
        else $error("Port registers not all ones after reset.");

    a_latch_drives_pin: assert property ((CE && !st.port_dir[1][4]) |=>
        PIN_OUT[12] == $past(st.port_data[1][4]) && !PIN_OE_N[12])
        else $error("Output pin does not follow its data latch.");

    sequence s_rmw_read;
        st.fsm == S_RMW_READ && CE;
    endsequence

    sequence s_rmw_write;
        st.fsm == S_RMW_WRITE && CE && !st.op_dir;
    endsequence

    a_rmw_one_bit: assert property (s_rmw_read ##1 s_rmw_write |=>
        st.port_data[$past(st.op_port)] ==
        (($past(st.op_byte) & ~(8'h01 << $past(st.op_bit))) |
         ({7'h00, $past(st.op_set)} << $past(st.op_bit))))
        else $error("Bit operation changed more than the addressed bit.");

    a_wake_on_fall: assert property ((CE && SLEEP && st.wake_en[0]
        && st.port_a_prev[0] && !st.pin_s2[0]) |=> WAKE)
        else $error("No wake after port A falling edge.");

    a_timer2_a_dflt: assert property ((CE && TOUT_EN[4] && !st.out_remap[4]) |=>
        PIN_OUT[PIN_C3] == $past(TOUT[4]) && !PIN_OE_N[PIN_C3])
        else $error("Timer2 output A not on C3.");

    a_timer1_b3_alt: assert property ((CE && TOUT_EN[3] && st.out_remap[3]) |=>
        PIN_OUT[PIN_E4] == $past(TOUT[3]) && !PIN_OE_N[PIN_E4])
        else $error("Timer1 channel B third not on E4.");

    a_timer1_a_dflt: assert property ((CE && TOUT_EN[2] && !st.out_remap[2]) |=>
        PIN_OUT[PIN_A1] == $past(TOUT[2]) && !PIN_OE_N[PIN_A1])
        else $error("Timer1 channel A not on A1.");

    a_timer0_b_alt: assert property ((CE && TOUT_EN[1] && st.out_remap[1]) |=>
        PIN_OUT[PIN_D5] == $past(TOUT[1]) && !PIN_OE_N[PIN_D5])
        else $error("Timer0 output B not on D5.");

    a_timer3_a_alt: assert property ((CE && LARGE_VARIANT && TOUT_EN[6]
        && st.out_remap[6]) |=> PIN_OUT[PIN_E5] == $past(TOUT[6]) && !PIN_OE_N[PIN_E5])
        else $error("Timer3 output A not on E5.");

    a_small_t3_ignored: assert property ((CE && !LARGE_VARIANT) |=>
        PIN_OE_N[PIN_D3] == $past(st.port_dir[3][3]))
        else $error("Small variant drives a timer3 output.");

    a_old_pin_freed: assert property ((CE && st.out_remap[0]) |=>
        PIN_OUT[PIN_A0] == $past(st.port_data[0][0])
        && PIN_OE_N[PIN_A0] == $past(st.port_dir[0][0]))
        else $error("Previous timer0 output pin not released.");

    a_irq1_a4_route: assert property ((CE && st.in_remap[3:2] == 2'h0) |=>
        IRQ_IN[1] == $past(st.pin_s2[PIN_A4]))
        else $error("Irq1 not taken from A4.");

    a_irq0_c4_route: assert property ((CE && st.in_remap[1:0] == 2'h1) |=>
        IRQ_IN[0] == $past(st.pin_s2[PIN_C4]))
        else $error("Irq0 not taken from C4.");

    a_wake_needs_sleep: assert property ((CE && !SLEEP) |=> !WAKE)
        else $error("Wake raised while not sleeping.");

    a_busy_holds_wait: assert property (st.fsm != S_IDLE |-> WAITREQUEST)
        else $error("Bus access accepted during a bit operation.");

endmodule

/* File: testbench.sv */
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("CHECK FAILED %s expected %h seen %h", n, e, g); errors++; end end

module testbench
    import pin_remap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Signals and bookkeeping.
    typedef struct {string n; logic [63:0] e;} note_t;
    logic core_clk = 1'b0;
    logic rst_n, ce, read, write, waitrequest, sleep, wake, obs_vld;
    logic [7:0] address, tout, tout_en;
    logic [31:0] writedata, readdata, readdata_s;
    logic [3:0] byteenable;
    logic [55:0] pin_in, pin_out, pin_oe_n;
    logic [2:0] tmr_clk_in;
    logic [1:0] irq_in;
    logic [63:0] obs;
    logic [15:0] seed = 16'h56CA;
    logic [5:0] cp [8] = '{PIN_A0, PIN_C5, PIN_A1, PIN_C5, PIN_C3, PIN_C4, PIN_D3, PIN_D0};
    logic [5:0] sp [8] = '{PIN_C6, PIN_D5, PIN_C7, PIN_E4, PIN_D1, PIN_D4, PIN_E5, PIN_E3};
    logic [5:0] i0 [4] = '{PIN_A3, PIN_C4, PIN_E0, PIN_E6};
    logic [5:0] i1 [4] = '{PIN_A4, PIN_C5, PIN_E1, PIN_E7};
    note_t notes[$];
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 core_clk = ~core_clk;

    peripheral_pin_remap dut_u (
        .CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .ADDRESS(address), .READ(read),
        .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
        .WAITREQUEST(waitrequest), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
        .TOUT(tout), .TOUT_EN(tout_en), .TMR_CLK_IN(tmr_clk_in), .IRQ_IN(irq_in),
        .SLEEP(sleep), .WAKE(wake)
    );

    peripheral_pin_remap #(.LARGE_VARIANT(1'b0)) dut_small_u (
        .CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .ADDRESS(address), .READ(read),
        .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata_s),
        .WAITREQUEST(), .PIN_IN(pin_in), .PIN_OUT(), .PIN_OE_N(), .TOUT(tout),
        .TOUT_EN(tout_en), .TMR_CLK_IN(), .IRQ_IN(), .SLEEP(sleep), .WAKE()
    );

    // ==========================================================
    // Helpers.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd(output logic [63:0] r);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            r = {r[47:0], seed};
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge core_clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        notes.push_back('{n, {56'h0, e}});
        bus(a, 1'b0, 32'h0, 4'hF);
    endtask

    task automatic look(input string n, input logic [63:0] e, input logic [63:0] g);
        @(posedge core_clk);
        notes.push_back('{n, e});
        obs <= g;
        obs_vld <= 1'b1;
        @(posedge core_clk);
        obs_vld <= 1'b0;
    endtask

    task automatic out_scan();
        logic [63:0] r;
        logic [3:0] g;
        for (int i = 0; i < 8; i++) begin
            tout_en <= 8'(1 << i);
            for (int s = 0; s < 2; s++) begin
                rnd(r);
                tout <= r[7:0];
                wr(OFS_OUTPUT_REMAP, 32'(s << i));
                repeat (3) @(posedge core_clk);
                g = {pin_oe_n[cp[i]], pin_oe_n[sp[i]], pin_out[cp[i]], pin_out[sp[i]]};
                look("timer out pins", (s == 1) ? {60'h0, 3'h5, r[i]}
                                                : {60'h0, 2'h1, r[i], 1'b1}, 64'(g));
            end
        end
        tout_en <= 8'h00;
    endtask

    // ==========================================================
    // Result watcher and timeout.
    always @(posedge core_clk) begin
        note_t x;
        if ((read === 1'b1 && waitrequest === 1'b0) || obs_vld === 1'b1) begin
            x = notes.pop_front();
            `CHK(x.n, x.e, (obs_vld === 1'b1 ? obs : {32'h0, readdata}))
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        logic [63:0] r;
        logic [7:0] m, d;
        logic [2:0] e;
        logic seen;
        rst_n = 1'b0;
        ce = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        pin_in = 56'h0;
        tout = 8'h00;
        tout_en = 8'h00;
        sleep = 1'b0;
        obs_vld = 1'b0;
        obs = 64'h0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        look("pin_out reset", {8'h0, {56{1'b1}}}, {8'h0, pin_out});
        look("pin_oe_n reset", {8'h0, {56{1'b1}}}, {8'h0, pin_oe_n});
        rd(OFS_INPUT_REMAP, 8'h00, "input remap reset");
        rd(OFS_OUTPUT_REMAP, 8'h00, "output remap reset");
        for (int p = 0; p < 7; p++) begin
            rd(OFS_DATA_BASE + 8'(4 * p), 8'hFF, "data reset");
            rd(OFS_DIR_BASE + 8'(4 * p), 8'hFF, "dir reset");
        end
        rd(8'h1C, 8'h00, "unmapped");
        for (int k = 0; k < 16; k++) begin
            rnd(r);
            m = {k[2:0], r[60], k[3:0]};
            pin_in <= r[55:0];
            wr(OFS_INPUT_REMAP, {24'h0, m});
            repeat (4) @(posedge core_clk);
            e = {r[m[7] ? PIN_D0 : PIN_C2], r[m[6] ? PIN_D3 : PIN_A4], r[m[5] ? PIN_D2 : PIN_A2]};
            look("timer clock in", 64'(e), 64'(tmr_clk_in));
            look("irq in", 64'({r[i1[m[3:2]]], r[i0[m[1:0]]]}), 64'(irq_in));
            rd(OFS_INPUT_REMAP, m, "input remap");
        end
        ce <= 1'b0;
        pin_in <= ~r[55:0];
        repeat (6) @(posedge core_clk);
        look("clock in frozen", 64'(e), 64'(tmr_clk_in));
        ce <= 1'b1;
        bus(OFS_INPUT_REMAP, 1'b1, 32'hFF, 4'h0);
        rd(OFS_INPUT_REMAP, m, "masked write");
        out_scan();
        wr(OFS_OUTPUT_REMAP, 32'hFF);
        rd(OFS_OUTPUT_REMAP, 8'hFF, "output remap full");
        look("output remap small", 64'h3F, 64'(readdata_s));
        wr(OFS_DIR_BASE + 8'h04, 32'h0F);
        repeat (2) @(posedge core_clk);
        look("oe_n port b", 64'h0F, 64'(pin_oe_n[15:8]));
        look("out port b first", 64'hFF, 64'(pin_out[15:8]));
        rnd(r);
        d = r[7:0];
        wr(OFS_DATA_BASE + 8'h04, {24'h0, d});
        repeat (2) @(posedge core_clk);
        look("out port b", 64'(d), 64'(pin_out[15:8]));
        wr(OFS_BIT_OP, 32'h212);
        rd(OFS_DATA_BASE + 8'h04, d | 8'h04, "bit set");
        wr(OFS_BIT_OP, 32'h015);
        d = (d | 8'h04) & 8'hDF;
        rd(OFS_DATA_BASE + 8'h04, d, "bit clear");
        wr(OFS_BIT_OP, 32'h317);
        rd(OFS_DIR_BASE + 8'h04, 8'h8F, "dir bit set");
        look("out after bit ops", 64'(d), 64'(pin_out[15:8]));
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFS_DATA_BASE + 8'h04, 8'hFF, "data after reset");
        look("oe_n after reset", {8'h0, {56{1'b1}}}, {8'h0, pin_oe_n});
        pin_in <= {56{1'b1}};
        wr(OFS_WAKE_ENABLE, 32'h01);
        sleep <= 1'b1;
        repeat (5) @(posedge core_clk);
        pin_in[1] <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(posedge core_clk);
            seen = seen | (wake === 1'b1);
        end
        look("wake disabled pin", 64'h0, 64'(seen));
        pin_in[0] <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(posedge core_clk);
            seen = seen | (wake === 1'b1);
        end
        look("wake enabled pin", 64'h1, 64'(seen));
        stop_test();
    end
endmodule
